/* rtl/ccs_clock_ctrl.sv */
// clock source, system clock select and oscillator control registers
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module ccs_clock_ctrl #(
  parameter int WAIT_65536 = 65536,
  parameter int WAIT_16384 = 16384,
  parameter int WAIT_8192 = 8192,
  parameter int WAIT_4096 = 4096
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic sleep_enter_i,
  input wire logic wake_i,
  input wire logic stop_detect_i,
  input wire logic trim_done_i,
  input wire logic trim_error_i,
  output logic [3:0] src_on_o,
  output logic [1:0] sys_source_o,
  output logic [2:0] sys_div_log2_o,
  output logic [1:0] rc_freq_select_o,
  output logic voltage_mode_select_o,
  output logic slow_type_select_o,
  output logic [2:0] slow_gate_cap_o,
  output logic [1:0] slow_gain_o,
  output logic stop_detect_enable_o,
  output logic slow_restart_o,
  output logic [1:0] fast_freq_select_o,
  output logic fast_type_select_o,
  output logic [1:0] fast_gain_o,
  output logic trim_run_o
);
  typedef struct packed {
    logic [15:0] sclk;
    logic [15:0] osc;
    logic [15:0] iosc;
    logic [15:0] osc1;
    logic [15:0] osc3;
    logic [15:0] pwr;
    logic [15:0] flags;
    logic [15:0] rdata;
    logic prot_open;
    ccs_pkg::ccs_mode_type mode;
    logic [3:0] run;
    logic [2:0] sync;
    logic stop_lvl;
    logic restart;
    logic trim;
    logic slow_ok;
  } ccs_state_type;
  ccs_state_type st_ff, nxt_st;

  localparam logic [ccs_pkg::WAIT_W-1:0] L65536 = ccs_pkg::WAIT_W'(WAIT_65536);
  localparam logic [ccs_pkg::WAIT_W-1:0] L16384 = ccs_pkg::WAIT_W'(WAIT_16384);
  localparam logic [ccs_pkg::WAIT_W-1:0] L8192 = ccs_pkg::WAIT_W'(WAIT_8192);
  localparam logic [ccs_pkg::WAIT_W-1:0] L4096 = ccs_pkg::WAIT_W'(WAIT_4096);

  logic slow_done;
  logic fast_done;
  logic [ccs_pkg::WAIT_W-1:0] slow_lim;
  logic [ccs_pkg::WAIT_W-1:0] fast_lim;
  logic [1:0] src;
  logic [1:0] dcode;
  logic wr_ok;
  logic stop_seen;

  // per-source divider table
  // divider code to shift amount per source, reserved codes fall back
  function automatic logic [2:0] div_log2(input logic [1:0] s, input logic [1:0] d);
    logic [2:0] r;
    r = 3'h0;
    case (s)
      ccs_pkg::SRC_RC: r = {1'b0, d};
      ccs_pkg::SRC_SLOW: r = {2'b00, d[0]};
      ccs_pkg::SRC_FAST: r = (d[1]) ? {1'b0, d} + 3'h1 : {2'b00, d[0]};
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  // stabilisation wait per code, unusable codes take the longest wait
  always_comb begin
    case (st_ff.osc1[ccs_pkg::WT_POS +: 2])
      2'h3: slow_lim = L65536;
      2'h2: slow_lim = L16384;
      2'h1: slow_lim = L4096;
      default: slow_lim = L65536;
    endcase
    case (st_ff.osc3[ccs_pkg::WT_POS +: 3])
      3'h7: fast_lim = L65536;
      3'h6: fast_lim = L16384;
      3'h5: fast_lim = L8192;
      3'h4: fast_lim = L4096;
      default: fast_lim = L65536;
    endcase
  end

  // wait timers restart whenever the oscillator stops or restarts
  ccs_stab_timer #(.W(ccs_pkg::WAIT_W)) u_slow_tmr (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .run_i(st_ff.run[ccs_pkg::SRC_SLOW] & ~st_ff.restart),
    .limit_i(slow_lim),
    .done_o(slow_done)
  );

  ccs_stab_timer #(.W(ccs_pkg::WAIT_W)) u_fast_tmr (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .run_i(st_ff.run[ccs_pkg::SRC_FAST]),
    .limit_i(fast_lim),
    .done_o(fast_done)
  );

  // detector level moves only when the last two stages agree
  assign stop_seen = (st_ff.sync[1] == st_ff.sync[2]) && st_ff.sync[2] && !st_ff.stop_lvl;
  assign wr_ok = wr_i && st_ff.prot_open;

  // register writes, wake reload, source tracking and flags
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync = {st_ff.sync[1:0], stop_detect_i};
    if (st_ff.sync[1] == st_ff.sync[2]) begin
      nxt_st.stop_lvl = st_ff.sync[2];
    end
    src = st_ff.sclk[ccs_pkg::SRC_POS +: 2];
    dcode = st_ff.sclk[ccs_pkg::DIV_POS +: 2];
    if (wr_i && addr_i == ccs_pkg::PROT_OFS) begin
      nxt_st.prot_open = (wdata_i == ccs_pkg::PROT_KEY);
    end
    // source select, starts the chosen source
    if (wr_ok && addr_i == ccs_pkg::SCLK_OFS) begin
      nxt_st.sclk = wdata_i & ccs_pkg::SCLK_MASK;
      nxt_st.osc[ccs_pkg::EN_POS + int'(wdata_i[ccs_pkg::SRC_POS +: 2])] = 1'b1;
    end
    if (wr_i && addr_i == ccs_pkg::OSC_OFS) begin
      nxt_st.osc = wdata_i & ccs_pkg::OSC_MASK;
      nxt_st.osc[ccs_pkg::EN_POS + int'(src)] = 1'b1;
    end
    if (wr_ok && addr_i == ccs_pkg::IOSC_OFS) begin
      nxt_st.iosc = wdata_i & ccs_pkg::IOSC_MASK;
    end
    if (wr_ok && addr_i == ccs_pkg::OSC1_OFS) begin
      nxt_st.osc1 = wdata_i & ccs_pkg::OSC1_MASK;
    end
    // trim start and stop by software
    if (wr_ok && addr_i == ccs_pkg::OSC3_OFS) begin
      nxt_st.osc3 = wdata_i & ccs_pkg::OSC3_MASK;
      nxt_st.trim = wdata_i[ccs_pkg::TRIM_POS];
    end
    if (wr_ok && addr_i == ccs_pkg::PWR_OFS) begin
      nxt_st.pwr = wdata_i & ccs_pkg::PWR_MASK;
    end
    // flags clear by writing 1, set below wins
    if (wr_i && addr_i == ccs_pkg::FLAG_OFS) begin
      nxt_st.flags = st_ff.flags & ~wdata_i;
    end
    // trimming ends itself on done or error
    if (trim_done_i || trim_error_i) begin
      nxt_st.trim = 1'b0;
    end
    // no trimming without the slow oscillator
    if (!st_ff.run[ccs_pkg::SRC_SLOW]) begin
      nxt_st.trim = 1'b0;
    end
    if (trim_error_i) begin
      nxt_st.flags[ccs_pkg::TERR_FLAG] = 1'b1;
    end
    if (slow_done) begin
      nxt_st.flags[ccs_pkg::SLOW_FLAG] = 1'b1;
    end
    if (fast_done) begin
      nxt_st.flags[ccs_pkg::FAST_FLAG] = 1'b1;
    end
    // restart slow oscillator on detected stop
    nxt_st.restart = stop_seen && st_ff.osc1[ccs_pkg::DET_POS]
                     && st_ff.osc1[ccs_pkg::RSTEN_POS] && st_ff.run[ccs_pkg::SRC_SLOW];
    // sleep entry and wake-up sequencing
    case (st_ff.mode)
      ccs_pkg::CCS_RUN: begin
        if (sleep_enter_i) begin
          nxt_st.mode = ccs_pkg::CCS_SLEEP;
        end
      end
      ccs_pkg::CCS_SLEEP: begin
        if (wake_i) begin
          nxt_st.mode = ccs_pkg::CCS_RUN;
          // wake reload of source and divider
          if (st_ff.sclk[ccs_pkg::WMD_POS]) begin
            nxt_st.sclk[ccs_pkg::SRC_POS +: 2] = st_ff.sclk[ccs_pkg::WSRC_POS +: 2];
            nxt_st.sclk[ccs_pkg::DIV_POS +: 2] = st_ff.sclk[ccs_pkg::WDIV_POS +: 2];
            nxt_st.osc[ccs_pkg::EN_POS + int'(st_ff.sclk[ccs_pkg::WSRC_POS +: 2])] = 1'b1;
          end
        end
      end
      default: nxt_st.mode = ccs_pkg::CCS_RUN;
    endcase
    // sleep-stop gating of each enabled source
    for (int i = 0; i < 4; i++) begin
      nxt_st.run[i] = nxt_st.osc[ccs_pkg::EN_POS + i]
                      && !(nxt_st.mode == ccs_pkg::CCS_SLEEP && nxt_st.osc[ccs_pkg::SLP_POS + i]);
    end
    // startup phase ends at the first completed slow wait
    if (slow_done) begin
      nxt_st.slow_ok = 1'b1;
    end
    // a stopped or restarted slow oscillator boosts again, flag clears do not
    if (!nxt_st.run[ccs_pkg::SRC_SLOW] || nxt_st.restart) begin
      nxt_st.slow_ok = 1'b0;
    end
    // read data stands in the next cycle
    nxt_st.rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        ccs_pkg::SCLK_OFS: nxt_st.rdata = st_ff.sclk;
        ccs_pkg::OSC_OFS: nxt_st.rdata = st_ff.osc;
        ccs_pkg::IOSC_OFS: nxt_st.rdata = st_ff.iosc;
        ccs_pkg::OSC1_OFS: nxt_st.rdata = st_ff.osc1;
        ccs_pkg::OSC3_OFS: nxt_st.rdata = {st_ff.osc3[15:4], st_ff.trim, st_ff.osc3[2:0]};
        ccs_pkg::FLAG_OFS: nxt_st.rdata = st_ff.flags;
        ccs_pkg::PROT_OFS: nxt_st.rdata = {15'h0000, st_ff.prot_open};
        ccs_pkg::PWR_OFS: nxt_st.rdata = st_ff.pwr;
        default: nxt_st.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      st_ff <= '{sclk: ccs_pkg::SCLK_RST, osc: ccs_pkg::OSC_RST, iosc: ccs_pkg::IOSC_RST,
                 osc1: ccs_pkg::OSC1_RST, osc3: ccs_pkg::OSC3_RST, pwr: ccs_pkg::PWR_RST,
                 flags: 16'h0000, rdata: 16'h0000, prot_open: 1'b0,
                 mode: ccs_pkg::CCS_RUN, run: 4'h1, sync: 3'h0, stop_lvl: 1'b0,
                 restart: 1'b0, trim: 1'b0, slow_ok: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state
  assign rdata_o = st_ff.rdata;
  assign src_on_o = st_ff.run;
  assign sys_source_o = src;
  assign sys_div_log2_o = div_log2(src, dcode);
  // high rc code is replaced in mode1
  assign voltage_mode_select_o = st_ff.pwr[ccs_pkg::VMODE_POS];
  assign rc_freq_select_o = (!voltage_mode_select_o
                             && st_ff.iosc[1:0] >= ccs_pkg::RC_FQ_HIGH)
                            ? ccs_pkg::RC_FQ_MODE1_MAX : st_ff.iosc[1:0];
  assign slow_type_select_o = st_ff.osc1[ccs_pkg::STYPE_POS];
  assign slow_gate_cap_o = st_ff.osc1[ccs_pkg::CAP_POS +: 3];
  // boost gain until slow is stable
  assign slow_gain_o = (st_ff.osc1[ccs_pkg::BOOST_POS] && !st_ff.slow_ok)
                       ? st_ff.osc1[ccs_pkg::BGAIN_POS +: 2]
                       : st_ff.osc1[ccs_pkg::NGAIN_POS +: 2];
  assign stop_detect_enable_o = st_ff.osc1[ccs_pkg::DET_POS];
  assign slow_restart_o = st_ff.restart;
  assign fast_freq_select_o = st_ff.osc3[ccs_pkg::FFQ_POS +: 2];
  // gain only matters for crystal type
  assign fast_type_select_o = st_ff.osc3[ccs_pkg::FTYPE_POS];
  assign fast_gain_o = st_ff.osc3[ccs_pkg::FGAIN_POS +: 2];
  assign trim_run_o = st_ff.trim;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  a_wake_load: assert property (st_ff.mode == ccs_pkg::CCS_SLEEP && wake_i
    && st_ff.sclk[ccs_pkg::WMD_POS] |=> sys_source_o == $past(st_ff.sclk[9:8]))
    else $error("wake source not loaded");
  a_wake_hold: assert property (st_ff.mode == ccs_pkg::CCS_SLEEP && wake_i
    && !st_ff.sclk[ccs_pkg::WMD_POS] && !wr_i |=> $stable(st_ff.sclk[5:0]))
    else $error("system clock changed at wake");
  a_wake_start: assert property (st_ff.mode == ccs_pkg::CCS_SLEEP && wake_i
    && st_ff.sclk[ccs_pkg::WMD_POS] |=> st_ff.osc[st_ff.sclk[1:0]])
    else $error("wake source not started");
  a_sel_start: assert property (wr_ok && addr_i == ccs_pkg::SCLK_OFS
    |=> st_ff.osc[sys_source_o] ##1 src_on_o[sys_source_o] || st_ff.mode != ccs_pkg::CCS_RUN)
    else $error("selected source not started");
  a_sleep_stop: assert property (st_ff.mode == ccs_pkg::CCS_SLEEP && st_ff.osc[9]
    |-> !src_on_o[1])
    else $error("slow source ran in sleep");
  a_restart: assert property (stop_seen && stop_detect_enable_o
    && st_ff.osc1[ccs_pkg::RSTEN_POS] && src_on_o[1] |=> slow_restart_o)
    else $error("slow restart missing");
  a_trim_slow: assert property (trim_run_o |-> $past(src_on_o[1]))
    else $error("trim without slow oscillator");
  a_trim_end: assert property (trim_done_i && !wr_ok |=> !trim_run_o)
    else $error("trim bit not cleared");
  a_err_flag: assert property (trim_error_i |=> st_ff.flags[ccs_pkg::TERR_FLAG] ##1
    st_ff.flags[ccs_pkg::TERR_FLAG] || $past(wr_i))
    else $error("trim error flag lost");
  a_gain_sel: assert property (!st_ff.osc1[ccs_pkg::BOOST_POS]
    |-> slow_gain_o == st_ff.osc1[5:4])
    else $error("wrong slow gain");

  // register protection, field limits and source state
  a_prot_block: assert property (wr_i && !st_ff.prot_open && addr_i == ccs_pkg::SCLK_OFS
    && st_ff.mode == ccs_pkg::CCS_RUN |=> $stable(st_ff.sclk))
    else $error("protected write took effect");
  a_rc_mode1: assert property (!voltage_mode_select_o
    |-> rc_freq_select_o < ccs_pkg::RC_FQ_HIGH)
    else $error("rc code too high in mode1");
  a_ext_div: assert property (sys_source_o == ccs_pkg::SRC_EXT
    |-> sys_div_log2_o == 3'h0)
    else $error("external source divided");
  a_run_enable: assert property (st_ff.mode == ccs_pkg::CCS_RUN
    |-> src_on_o == st_ff.osc[3:0])
    else $error("source state differs from enable");
  a_sleep_keep: assert property (st_ff.mode == ccs_pkg::CCS_SLEEP && !st_ff.osc[10]
    && st_ff.osc[2] |-> src_on_o[2])
    else $error("fast source stopped in sleep");
  a_boost_start: assert property (!src_on_o[1] && st_ff.osc1[ccs_pkg::BOOST_POS]
    |-> slow_gain_o == st_ff.osc1[7:6])
    else $error("boost gain not applied");
  a_slow_flag: assert property (slow_done |=> st_ff.flags[ccs_pkg::SLOW_FLAG])
    else $error("slow stable flag not set");
  a_fast_flag: assert property (fast_done |=> st_ff.flags[ccs_pkg::FAST_FLAG])
    else $error("fast stable flag not set");
  a_restart_once: assert property (slow_restart_o |=> !slow_restart_o)
    else $error("restart pulse too long");
  a_trim_stop: assert property (!src_on_o[1] |=> !trim_run_o)
    else $error("trim started without slow oscillator");

  c_wake_switch: cover property (st_ff.mode == ccs_pkg::CCS_SLEEP && wake_i
    && st_ff.sclk[ccs_pkg::WMD_POS]);
  c_slow_stable: cover property (slow_done);
  c_restart: cover property (slow_restart_o);
  c_trim_error: cover property (trim_run_o ##1 trim_error_i);
  c_wake_hold: cover property (st_ff.mode == ccs_pkg::CCS_SLEEP && wake_i
    && !st_ff.sclk[ccs_pkg::WMD_POS]);
endmodule

/* rtl/ccs_pkg.sv */
// constants, register map and types of the clock source controller
package ccs_pkg;
  // register byte offsets
  localparam logic [7:0] SCLK_OFS = 8'h00;
  localparam logic [7:0] OSC_OFS = 8'h04;
  localparam logic [7:0] IOSC_OFS = 8'h08;
  localparam logic [7:0] OSC1_OFS = 8'h0C;
  localparam logic [7:0] OSC3_OFS = 8'h10;
  localparam logic [7:0] FLAG_OFS = 8'h14;
  localparam logic [7:0] PROT_OFS = 8'h18;
  localparam logic [7:0] PWR_OFS = 8'h1C;
  // writable bits and reset values
  localparam logic [15:0] SCLK_MASK = 16'hB333;
  localparam logic [15:0] SCLK_RST = 16'h0020;
  localparam logic [15:0] OSC_MASK = 16'h0F0F;
  localparam logic [15:0] OSC_RST = 16'h0F01;
  localparam logic [15:0] IOSC_MASK = 16'h0003;
  localparam logic [15:0] IOSC_RST = 16'h0002;
  localparam logic [15:0] OSC1_MASK = 16'h7FF3;
  localparam logic [15:0] OSC1_RST = 16'h5092;
  localparam logic [15:0] OSC3_MASK = 16'h0E3F;
  localparam logic [15:0] OSC3_RST = 16'h0436;
  localparam logic [15:0] PWR_MASK = 16'h0010;
  localparam logic [15:0] PWR_RST = 16'h0010;
  localparam logic [15:0] PROT_KEY = 16'h0096;
  // field positions
  localparam int SRC_POS = 0;
  localparam int DIV_POS = 4;
  localparam int WSRC_POS = 8;
  localparam int WDIV_POS = 12;
  localparam int WMD_POS = 15;
  localparam int EN_POS = 0;
  localparam int SLP_POS = 8;
  localparam int WT_POS = 0;
  localparam int NGAIN_POS = 4;
  localparam int BGAIN_POS = 6;
  localparam int CAP_POS = 8;
  localparam int STYPE_POS = 11;
  localparam int BOOST_POS = 12;
  localparam int DET_POS = 13;
  localparam int RSTEN_POS = 14;
  localparam int TRIM_POS = 3;
  localparam int FGAIN_POS = 4;
  localparam int FTYPE_POS = 9;
  localparam int FFQ_POS = 10;
  localparam int VMODE_POS = 4;
  localparam int RC_FLAG = 0;
  localparam int SLOW_FLAG = 1;
  localparam int FAST_FLAG = 2;
  localparam int TERR_FLAG = 8;
  // source codes
  localparam logic [1:0] SRC_RC = 2'h0;
  localparam logic [1:0] SRC_SLOW = 2'h1;
  localparam logic [1:0] SRC_FAST = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  // lowest rc frequency code that mode1 forbids, and its substitute
  localparam logic [1:0] RC_FQ_HIGH = 2'h2;
  localparam logic [1:0] RC_FQ_MODE1_MAX = 2'h1;
  // stabilisation waits in oscillator clocks
  localparam int WAIT_W = 17;
  typedef enum logic {CCS_RUN, CCS_SLEEP} ccs_mode_type;
endpackage

/* rtl/ccs_stab_timer.sv */
// stabilisation wait counter for one oscillator
`timescale 1ns/1ps
module ccs_stab_timer #(
  parameter int W = 17
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic run_i,
  input wire logic [W-1:0] limit_i,
  output logic done_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic busy;
    logic done;
  } ccs_tmr_type;
  ccs_tmr_type st_ff, nxt_st;

  // count from start until the limit, then pulse once
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (!run_i) begin
      nxt_st.cnt = '0;
      nxt_st.busy = 1'b1;
    end else if (st_ff.busy) begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
      if (st_ff.cnt + 1'b1 >= limit_i) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      st_ff <= '{cnt: '0, busy: 1'b1, done: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done_o = st_ff.done;
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the clock source controller
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_i;
  logic resetn_i;
  logic [7:0] addr_i;
  logic [15:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [15:0] rdata_o;
  logic [3:0] ev;
  logic stop_detect_i;
  logic [3:0] src_on_o;
  logic [1:0] sys_source_o, rc_freq_select_o, slow_gain_o, fast_freq_select_o, fast_gain_o;
  logic [2:0] sys_div_log2_o, slow_gate_cap_o;
  logic voltage_mode_select_o, slow_type_select_o, stop_detect_enable_o, slow_restart_o;
  logic fast_type_select_o, trim_run_o;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  logic [15:0] r;
  logic seen;
  // log2 of division per source and code, 7 marks reserved
  localparam logic [2:0] LG [4][4] = '{'{3'h0, 3'h1, 3'h2, 3'h3}, '{3'h0, 3'h1, 3'h7, 3'h7},
                                       '{3'h0, 3'h1, 3'h3, 3'h4}, '{3'h0, 3'h7, 3'h7, 3'h7}};
  localparam logic [7:0] OFS [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h18, 8'h20};
  localparam logic [15:0] RST [9] = '{16'h0020, 16'h0F01, 16'h0002, 16'h5092, 16'h0436, 16'h0000,
                                     16'h0010, 16'h0000, 16'h0000};

  ccs_clock_ctrl #(.WAIT_65536(64), .WAIT_16384(32), .WAIT_8192(16), .WAIT_4096(8)) dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_enter_i(ev[0]), .wake_i(ev[1]),
    .stop_detect_i(stop_detect_i), .trim_done_i(ev[2]), .trim_error_i(ev[3]),
    .src_on_o(src_on_o), .sys_source_o(sys_source_o), .sys_div_log2_o(sys_div_log2_o),
    .rc_freq_select_o(rc_freq_select_o), .voltage_mode_select_o(voltage_mode_select_o),
    .slow_type_select_o(slow_type_select_o), .slow_gate_cap_o(slow_gate_cap_o),
    .slow_gain_o(slow_gain_o), .stop_detect_enable_o(stop_detect_enable_o),
    .slow_restart_o(slow_restart_o), .fast_freq_select_o(fast_freq_select_o),
    .fast_type_select_o(fast_type_select_o), .fast_gain_o(fast_gain_o), .trim_run_o(trim_run_o));

  // 100 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    @(negedge ref_clk_i);
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    d = rdata_o;
  endtask

  // one-cycle event pulse: {trim error, trim done, wake, sleep}
  task automatic pulse(input logic [3:0] k);
    @(posedge ref_clk_i);
    ev <= k;
    @(posedge ref_clk_i);
    ev <= 4'h0;
    @(negedge ref_clk_i);
  endtask

  initial begin
    resetn_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    ev = 4'h0;
    stop_detect_i = 1'b0;
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(OFS[i], r);
      chk(r, RST[i]);
    end
    chk(16'(src_on_o), 16'h0001);
    // system clock select write refused while protected
    wr(8'h00, 16'h0011);
    rd(8'h00, r);
    chk(r, 16'h0020);
    wr(8'h18, 16'h0096);
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 4; c++) begin
        if (LG[s][c] != 3'h7) begin
          wr(8'h00, {10'h000, c[1:0], 2'h0, s[1:0]});
          chk(16'(sys_source_o), 16'(s));
          chk(16'(sys_div_log2_o), 16'(LG[s][c]));
          chk(16'(src_on_o[s]), 16'h0001);
        end
      end
    end
    wr(8'h00, 16'h0020);
    wr(8'h1C, 16'h0000);
    chk(16'(voltage_mode_select_o), 16'h0000);
    chk(16'(rc_freq_select_o), 16'h0001);
    wr(8'h1C, 16'h0010);
    chk(16'(rc_freq_select_o), 16'h0002);
    // slow start, boost gain then normal gain
    wr(8'h04, 16'h0F01);
    wr(8'h14, 16'h0006);
    wr(8'h04, 16'h0F03);
    chk(16'(slow_gain_o), 16'h0002);
    r = 16'h0000;
    for (int n = 0; n < 40 && r[1] !== 1'b1; n++) begin
      rd(8'h14, r);
    end
    chk(r & 16'h0002, 16'h0002);
    chk(16'(slow_gain_o), 16'h0001);
    wr(8'h14, 16'h0002);
    rd(8'h14, r);
    chk(r & 16'h0002, 16'h0000);
    chk(16'(slow_gain_o), 16'h0001);
    // slow type select set and gate capacitance at its top code 7
    wr(8'h0C, 16'h5F92);
    chk(16'(slow_type_select_o), 16'h0001);
    chk(16'(slow_gate_cap_o), 16'h0007);
    // stop detection restarts the slow oscillator
    // detector enabled once slow is stable
    wr(8'h0C, 16'h7092);
    chk(16'(stop_detect_enable_o), 16'h0001);
    seen = 1'b0;
    @(posedge ref_clk_i);
    stop_detect_i <= 1'b1;
    for (int n = 0; n < 10; n++) begin
      @(negedge ref_clk_i);
      if (slow_restart_o === 1'b1) seen = 1'b1;
    end
    @(posedge ref_clk_i);
    stop_detect_i <= 1'b0;
    chk(16'(seen), 16'h0001);
    repeat (40) @(posedge ref_clk_i);
    wr(8'h10, 16'h0E06);
    chk(16'(fast_freq_select_o), 16'h0003);
    chk(16'(fast_type_select_o), 16'h0001);
    chk(16'(fast_gain_o), 16'h0000);
    // trim runs, reads busy, clears at finish
    wr(8'h10, 16'h0E0E);
    chk(16'(trim_run_o), 16'h0001);
    rd(8'h10, r);
    chk(r, 16'h0E0E);
    pulse(4'h4);
    chk(16'(trim_run_o), 16'h0000);
    rd(8'h10, r);
    chk(r, 16'h0E06);
    // trim error flag set and cleared by writing 1
    wr(8'h10, 16'h0E0E);
    pulse(4'h8);
    chk(16'(trim_run_o), 16'h0000);
    rd(8'h14, r);
    chk(r & 16'h0100, 16'h0100);
    wr(8'h14, 16'h0100);
    rd(8'h14, r);
    chk(r & 16'h0100, 16'h0000);
    // detector off before slow stops, then no trimming
    wr(8'h0C, 16'h5092);
    wr(8'h04, 16'h0F05);
    wr(8'h10, 16'h0E0E);
    chk(16'(trim_run_o), 16'h0000);
    // sleep stops slow only, wake loads fast 1/16
    wr(8'h04, 16'h0203);
    wr(8'h00, 16'hB220);
    pulse(4'h1);
    chk(16'(src_on_o[1:0]), 16'h0001);
    pulse(4'h2);
    chk(16'(sys_source_o), 16'h0002);
    chk(16'(sys_div_log2_o), 16'h0004);
    chk(16'(src_on_o[2]), 16'h0001);
    rd(8'h00, r);
    chk(r, 16'hB232);
    // switching disabled leaves source and divider
    wr(8'h00, 16'h0310);
    pulse(4'h1);
    pulse(4'h2);
    chk(16'(sys_source_o), 16'h0000);
    chk(16'(sys_div_log2_o), 16'h0001);
    print_verdict();
  end
endmodule
